// ===== design/srap_map.svh
`ifndef SRAP_MAP_SVH
`define SRAP_MAP_SVH

////////////////////////////////////////////////////////////////////////////
// register map
`define SRAP_ADDR_STATUS_COPY 8'h61
`define SRAP_ADDR_SRC0_HIGH 8'h63
`define SRAP_ADDR_SRC1_HIGH 8'h65
`define SRAP_ADDR_TIME3 8'h69
`define SRAP_ADDR_SRC0_SEL 8'h44
`define SRAP_ADDR_SRC1_SEL 8'h45
`define SRAP_WRAP_EN_BIT 0
`define SRAP_PTR_MAX 8'hff
`define SRAP_PTR_RESET 8'h00
`define SRAP_REG_RESET 8'h00
`define SRAP_SENSOR_WIDTH 72

////////////////////////////////////////////////////////////////////////////
// i2c framing
`define SRAP_I2C_OWN_ADDR 7'h2a
`define SRAP_I2C_BYTE_BITS 4'h8

////////////////////////////////////////////////////////////////////////////
// spi frame fields
`define SRAP_SPI_LAST_BIT 6'h1f
`define SRAP_CMD_MSB 31
`define SRAP_CMD_LSB 28
`define SRAP_FIX_MSB 27
`define SRAP_FIX_LSB 24
`define SRAP_RA_MSB 23
`define SRAP_RA_LSB 16
`define SRAP_RD_MSB 15
`define SRAP_RD_LSB 8
`define SRAP_SENS_FIX_LSB 8
`define SRAP_CMD_READ 4'h1
`define SRAP_CMD_WRITE 4'h2
`define SRAP_CMD_SENSOR 4'h3

`endif

// ===== design/srap_pkg.sv
`default_nettype none
package srap_pkg;
  typedef logic [7:0] srap_byte_t;
  typedef logic [31:0] srap_frame_t;
  // gray steps along write path: addr, ack, reg, ack, data, ack
  typedef enum logic [3:0] {
    SRAP_I2C_IDLE = 4'h0,
    SRAP_I2C_ADDR = 4'h1,
    SRAP_I2C_ADDR_ACK = 4'h3,
    SRAP_I2C_REG = 4'h2,
    SRAP_I2C_REG_ACK = 4'h6,
    SRAP_I2C_WR_DATA = 4'h7,
    SRAP_I2C_WR_ACK = 4'h5,
    SRAP_I2C_RD_DATA = 4'h4,
    SRAP_I2C_RD_ACK = 4'hc,
    SRAP_I2C_WAIT = 4'hd
  } srap_i2c_state_t;
endpackage
`default_nettype wire

// ===== design/srap_sync.sv
`timescale 1ns/10ps
`default_nettype none
module srap_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input wire logic clk, // sampling clock
  input wire logic rst, // sync reset, high
  input wire logic [WIDTH-1:0] d, // asynchronous pins
  output logic [WIDTH-1:0] q // synchronised copy
);
  logic [WIDTH-1:0] meta_reg;

  ////////////////////////////////////////////////////////////////////////////
  // two flops per bit; first stage feeds only the second
  genvar i;
  generate
    for (i = 0; i < WIDTH; i = i + 1) begin : g_bit
      always_ff @(posedge clk) begin
        if (rst) begin
          meta_reg[i] <= RST_VAL[i];
          q[i] <= RST_VAL[i];
        end else begin
          meta_reg[i] <= d[i];
          q[i] <= meta_reg[i];
        end
      end
    end
  endgenerate
endmodule
`default_nettype wire

// ===== design/srap_regfile.sv
`timescale 1ns/10ps
`default_nettype none
`include "srap_map.svh"
module srap_regfile (
  input wire logic clk, // system clock
  input wire logic rst, // sync reset, high
  input wire logic wr_en, // write strobe
  input wire srap_pkg::srap_byte_t wr_addr, // write address
  input wire srap_pkg::srap_byte_t wr_data, // write data
  input wire srap_pkg::srap_byte_t rd_addr_a, // i2c read address
  output srap_pkg::srap_byte_t rd_data_a, // i2c read data
  input wire srap_pkg::srap_byte_t rd_addr_b, // spi read address
  output srap_pkg::srap_byte_t rd_data_b, // spi read data
  input wire logic [`SRAP_SENSOR_WIDTH-1:0] sensor_bytes, // live 61h..69h
  output logic [1:0] wrap_en // {source1, source0} wrap enables
);
  import srap_pkg::*;

  srap_byte_t mem [0:255];

  // sensor window is live, everything else comes from the array
  function automatic srap_byte_t read_byte(input srap_byte_t a);
    srap_byte_t off;
    off = a - `SRAP_ADDR_STATUS_COPY;
    if (a >= `SRAP_ADDR_STATUS_COPY && a <= `SRAP_ADDR_TIME3) begin
      read_byte = sensor_bytes[{off[3:0], 3'b000} +: 8];
    end else begin
      read_byte = mem[a];
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // writes into the sensor window are dropped: those bytes are read only
  always_ff @(posedge clk) begin
    if (rst) begin
      for (int k = 0; k < 256; k = k + 1) begin
        mem[k] <= `SRAP_REG_RESET;
      end
    end else if (wr_en && !(wr_addr >= `SRAP_ADDR_STATUS_COPY &&
                            wr_addr <= `SRAP_ADDR_TIME3)) begin
      mem[wr_addr] <= wr_data;
    end
  end

  // read ports; a process rather than an assign, so array writes and
  // sensor updates reach the outputs even while the address holds still
  always_comb begin
    rd_data_a = read_byte(rd_addr_a);
    rd_data_b = read_byte(rd_addr_b);
  end

  // wrap enable bits
  assign wrap_en = {mem[`SRAP_ADDR_SRC1_SEL][`SRAP_WRAP_EN_BIT],
                    mem[`SRAP_ADDR_SRC0_SEL][`SRAP_WRAP_EN_BIT]};
endmodule
`default_nettype wire

// ===== design/srap_top.sv
// How it works
// - read: start, address with write bit, ack, register address, ack
// - then repeated start, address with read bit set, device acks
// - device sends addressed bytes; host nacks last byte, then stop
// - pointer wraps to status copy past last enabled sensor byte
// - no source enabled: pointer rolls from ffh to 00h
// - only source 0 enabled: 63h goes back to 61h
// - only source 1 enabled: 65h goes back to 61h
// - both enabled: 69h goes back to 61h
// - spi client with fixed 32-bit frames, bit 31 first
// - spi clock idles low; sample on rise, change on fall
// - spi frames shift msb first in both directions
// - command frame first; response follows in next frame
// - clock and data ignored while select is high
// - three commands: register read, register write, and sensor data with status
// - i2c pointer advances after every data byte, read or write
// - wrong client address gets no acknowledge
`timescale 1ns/10ps
`default_nettype none
`include "srap_map.svh"
module srap_top #(
  parameter logic [6:0] OWN_ADDR = `SRAP_I2C_OWN_ADDR
) (
  input wire logic ref_clk, // system clock, 50 mhz
  input wire logic rst, // sync reset, high
  input wire logic i2c_scl_in, // i2c clock pin level
  input wire logic i2c_sda_in, // i2c data pin level
  output logic i2c_sda_out, // i2c data drive value
  output logic i2c_sda_oe_n, // low while pulling data low
  input wire logic spi_sclk, // spi clock pin
  input wire logic spi_ss_n, // spi client select, low active
  input wire logic spi_mosi, // spi host-out data
  output logic spi_miso, // spi client-out data
  output logic spi_miso_oe_n, // low while driving miso
  input wire logic [`SRAP_SENSOR_WIDTH-1:0] sensor_bytes, // 61h..69h
  output srap_pkg::srap_byte_t i2c_pointer, // current register pointer
  output logic i2c_busy, // i2c transaction in progress
  output logic spi_frame_error // last frame was not 32 bits
);
  import srap_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers and edge detection
  logic [4:0] pin_sync;
  logic scl_s, sda_s, sclk_s, ss_n_s, mosi_s;
  logic scl_d, sda_d, sclk_d, ss_n_d;
  logic scl_rise, scl_fall, i2c_start, i2c_stop;
  logic sclk_rise, sclk_fall;

  srap_sync #(
    .WIDTH(5),
    .RST_VAL(5'h1a)
  ) u_sync (
    .clk(ref_clk),
    .rst(rst),
    .d({i2c_scl_in, i2c_sda_in, spi_sclk, spi_ss_n, spi_mosi}),
    .q(pin_sync)
  );

  // unpack in the order the pins were packed
  assign {scl_s, sda_s, sclk_s, ss_n_s, mosi_s} = pin_sync;

  // previous samples, taken from the second stage only
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
      sclk_d <= 1'b0;
      ss_n_d <= 1'b1;
    end else begin
      scl_d <= scl_s;
      sda_d <= sda_s;
      sclk_d <= sclk_s;
      ss_n_d <= ss_n_s;
    end
  end

  // start and repeated start look the same, so one detector serves both
  assign scl_rise = scl_s & ~scl_d;
  assign scl_fall = ~scl_s & scl_d;
  assign i2c_start = scl_s & scl_d & sda_d & ~sda_s;
  assign i2c_stop = scl_s & scl_d & ~sda_d & sda_s;
  assign sclk_rise = sclk_s & ~sclk_d;
  assign sclk_fall = ~sclk_s & sclk_d;

  ////////////////////////////////////////////////////////////////////////////
  // register file and write arbitration
  srap_byte_t ptr_reg, rd_a, rd_b, spi_ra;
  srap_byte_t i2c_wdata_reg, spi_waddr_reg, spi_wdata_reg;
  logic i2c_wr_reg, spi_wr_reg;
  logic [1:0] wrap_en;
  srap_frame_t frame_word;

  // i2c wins a collision; both hosts at once is a board fault anyway
  srap_regfile u_regs (
    .clk(ref_clk),
    .rst(rst),
    .wr_en(i2c_wr_reg | spi_wr_reg),
    .wr_addr(i2c_wr_reg ? ptr_reg : spi_waddr_reg),
    .wr_data(i2c_wr_reg ? i2c_wdata_reg : spi_wdata_reg),
    .rd_addr_a(ptr_reg),
    .rd_data_a(rd_a),
    .rd_addr_b(spi_ra),
    .rd_data_b(rd_b),
    .sensor_bytes(sensor_bytes),
    .wrap_en(wrap_en)
  );

  // pointer step shared by the read and write paths
  function automatic srap_byte_t next_ptr(input srap_byte_t p,
                                          input logic [1:0] en);
    srap_byte_t last;
    unique case (en)
      2'b00: last = `SRAP_PTR_MAX;
      2'b01: last = `SRAP_ADDR_SRC0_HIGH;
      2'b10: last = `SRAP_ADDR_SRC1_HIGH;
      2'b11: last = `SRAP_ADDR_TIME3;
    endcase
    if (en != 2'b00 && p == last) begin
      next_ptr = `SRAP_ADDR_STATUS_COPY;
    end else begin
      next_ptr = p + 8'h01; // ffh rolls to 00h by itself
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // i2c client state machine
  srap_i2c_state_t state_reg;
  logic [3:0] bit_cnt_reg;
  srap_byte_t rx_reg, tx_reg;
  logic rw_reg, sda_oe_n_reg;

  // data changes only after scl falls, so start and stop stay unambiguous
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      state_reg <= SRAP_I2C_IDLE;
      bit_cnt_reg <= 4'h0;
      rx_reg <= 8'h00;
      tx_reg <= 8'h00;
      rw_reg <= 1'b0;
      ptr_reg <= `SRAP_PTR_RESET;
      sda_oe_n_reg <= 1'b1;
      i2c_wr_reg <= 1'b0;
      i2c_wdata_reg <= 8'h00;
    end else begin
      i2c_wr_reg <= 1'b0;
      if (i2c_stop) begin
        state_reg <= SRAP_I2C_IDLE;
        sda_oe_n_reg <= 1'b1;
      end else if (i2c_start) begin
        state_reg <= SRAP_I2C_ADDR;
        bit_cnt_reg <= 4'h0;
        sda_oe_n_reg <= 1'b1;
      end else begin
        unique case (state_reg)
          SRAP_I2C_IDLE, SRAP_I2C_WAIT: begin
            sda_oe_n_reg <= 1'b1;
          end
          SRAP_I2C_ADDR, SRAP_I2C_REG, SRAP_I2C_WR_DATA: begin
            if (scl_rise) begin
              rx_reg <= {rx_reg[6:0], sda_s};
              bit_cnt_reg <= bit_cnt_reg + 4'h1;
            end else if (scl_fall && bit_cnt_reg == `SRAP_I2C_BYTE_BITS) begin
              bit_cnt_reg <= 4'h0;
              if (state_reg == SRAP_I2C_ADDR) begin
                if (rx_reg[7:1] == OWN_ADDR) begin
                  rw_reg <= rx_reg[0];
                  sda_oe_n_reg <= 1'b0;
                  state_reg <= SRAP_I2C_ADDR_ACK;
                end else begin
                  state_reg <= SRAP_I2C_WAIT; // stays released
                end
              end else if (state_reg == SRAP_I2C_REG) begin
                ptr_reg <= rx_reg;
                sda_oe_n_reg <= 1'b0;
                state_reg <= SRAP_I2C_REG_ACK;
              end else begin
                i2c_wr_reg <= 1'b1;
                i2c_wdata_reg <= rx_reg;
                sda_oe_n_reg <= 1'b0;
                state_reg <= SRAP_I2C_WR_ACK;
              end
            end
          end
          SRAP_I2C_ADDR_ACK: begin
            if (scl_fall) begin
              if (rw_reg) begin
                tx_reg <= rd_a;
                sda_oe_n_reg <= rd_a[7];
                state_reg <= SRAP_I2C_RD_DATA;
              end else begin
                sda_oe_n_reg <= 1'b1;
                state_reg <= SRAP_I2C_REG;
              end
            end
          end
          SRAP_I2C_REG_ACK: begin
            if (scl_fall) begin
              sda_oe_n_reg <= 1'b1;
              state_reg <= SRAP_I2C_WR_DATA;
            end
          end
          SRAP_I2C_WR_ACK: begin
            if (scl_fall) begin
              sda_oe_n_reg <= 1'b1;
              ptr_reg <= next_ptr(ptr_reg, wrap_en);
              state_reg <= SRAP_I2C_WR_DATA;
            end
          end
          SRAP_I2C_RD_DATA: begin
            if (scl_rise) begin
              bit_cnt_reg <= bit_cnt_reg + 4'h1;
            end else if (scl_fall) begin
              if (bit_cnt_reg == `SRAP_I2C_BYTE_BITS) begin
                sda_oe_n_reg <= 1'b1; // host owns the ack slot
                bit_cnt_reg <= 4'h0;
                state_reg <= SRAP_I2C_RD_ACK;
              end else begin
                tx_reg <= {tx_reg[6:0], 1'b0};
                sda_oe_n_reg <= tx_reg[6]; // msb first
              end
            end
          end
          SRAP_I2C_RD_ACK: begin
            if (scl_rise) begin
              ptr_reg <= next_ptr(ptr_reg, wrap_en);
              if (sda_s) begin
                state_reg <= SRAP_I2C_WAIT; // nack ends the read
              end
            end else if (scl_fall) begin
              tx_reg <= rd_a;
              sda_oe_n_reg <= rd_a[7];
              state_reg <= SRAP_I2C_RD_DATA;
            end
          end
          default: begin
            state_reg <= SRAP_I2C_IDLE;
            sda_oe_n_reg <= 1'b1;
          end
        endcase
      end
    end
  end

  // open drain: only ever pull low, scl has no driver at all
  assign i2c_sda_out = 1'b0;
  assign i2c_sda_oe_n = sda_oe_n_reg;
  assign i2c_pointer = ptr_reg;
  assign i2c_busy = (state_reg != SRAP_I2C_IDLE);

  ////////////////////////////////////////////////////////////////////////////
  // spi shifter
  logic [5:0] spi_cnt_reg;
  srap_frame_t spi_rx_reg, spi_tx_reg, spi_resp_reg;
  logic miso_reg, frame_done, frame_err_reg;

  // whole incoming word as of the 32nd rising edge
  assign frame_word = {spi_rx_reg[30:0], mosi_s};
  assign frame_done = ~ss_n_s & sclk_rise &
                      (spi_cnt_reg == `SRAP_SPI_LAST_BIT);
  assign spi_ra = frame_word[`SRAP_RA_MSB:`SRAP_RA_LSB];

  // while deselected the response is parked so bit 31 is ready at once
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      spi_cnt_reg <= 6'h00;
      spi_rx_reg <= 32'h0000_0000;
      spi_tx_reg <= 32'h0000_0000;
      miso_reg <= 1'b0;
    end else if (ss_n_s) begin
      spi_cnt_reg <= 6'h00;
      spi_tx_reg <= spi_resp_reg;
      miso_reg <= spi_resp_reg[31];
    end else begin
      if (sclk_rise) begin
        spi_rx_reg <= frame_word; // sample on rise
        spi_cnt_reg <= spi_cnt_reg + 6'h01;
      end
      if (sclk_fall) begin
        spi_tx_reg <= {spi_tx_reg[30:0], 1'b0};
        miso_reg <= spi_tx_reg[30]; // change on fall
      end
    end
  end

  // frame length check at deselect; short frames are dropped, long frames act on their first 32 bits
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      frame_err_reg <= 1'b0;
    end else if (ss_n_s & ~ss_n_d) begin
      frame_err_reg <= (spi_cnt_reg !=
                        `SRAP_SPI_LAST_BIT + 6'h01);
    end
  end

  // command decode; the answer goes out in the following frame
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      spi_resp_reg <= 32'h0000_0000;
      spi_wr_reg <= 1'b0;
      spi_waddr_reg <= 8'h00;
      spi_wdata_reg <= 8'h00;
    end else begin
      spi_wr_reg <= 1'b0;
      if (frame_done) begin
        case (frame_word[`SRAP_CMD_MSB:`SRAP_CMD_LSB])
          `SRAP_CMD_READ: begin
            spi_resp_reg <= {frame_word[`SRAP_CMD_MSB:`SRAP_FIX_LSB], spi_ra,
                             rd_b, 8'h00};
          end
          `SRAP_CMD_WRITE: begin
            spi_wr_reg <= 1'b1;
            spi_waddr_reg <= spi_ra;
            spi_wdata_reg <= frame_word[`SRAP_RD_MSB:`SRAP_RD_LSB];
            spi_resp_reg <= {frame_word[31:8], 8'h00};
          end
          `SRAP_CMD_SENSOR: begin
            // nonzero fixed bits mean a corrupt command
            if (frame_word[`SRAP_FIX_MSB:`SRAP_SENS_FIX_LSB] ==
                20'h0_0000) begin
              spi_resp_reg <= {frame_word[`SRAP_CMD_MSB:`SRAP_CMD_LSB], 4'h0,
                               sensor_bytes[7:0], sensor_bytes[23:16],
                               8'h00}; // status plus data
            end else begin
              spi_resp_reg <= 32'h0000_0000;
            end
          end
          default: begin
            spi_resp_reg <= 32'h0000_0000; // unknown command answers zero
          end
        endcase
      end
    end
  end

  // spi pin drives and frame status
  assign spi_miso = miso_reg;
  assign spi_miso_oe_n = ss_n_s; // tristate while not selected
  assign spi_frame_error = frame_err_reg;
endmodule
`default_nettype wire

// ===== tb/srap_top_monitor.sv
`timescale 1ns/10ps
`default_nettype none
module srap_top_monitor (
  input wire logic ref_clk, // system clock
  input wire logic rst, // sync reset, high
  input wire logic i2c_scl_in, // scl pin level
  input wire logic i2c_sda_in, // sda pin level
  input wire logic i2c_sda_out, // sda drive value
  input wire logic i2c_sda_oe_n, // low while pulling sda
  input wire logic spi_ss_n, // spi select
  input wire logic spi_miso_oe_n, // low while driving miso
  input wire srap_pkg::srap_byte_t i2c_pointer, // register pointer
  input wire logic i2c_busy, // i2c transaction open
  input wire logic spi_frame_error // bad frame length flag
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////////////////
  // open drain: the device may only ever pull sda low
  a_sda_drive_low: assert property (i2c_sda_out == 1'b0)
    else $error("sda drive value not low");
  a_idle_release: assert property (!i2c_busy |-> i2c_sda_oe_n)
    else $error("sda pulled while idle");
  // ack or data may only start while the host holds scl low
  a_ack_scl_low: assert property (
    $fell(i2c_sda_oe_n) |-> !i2c_scl_in)
    else $error("sda pull began with scl high");
  a_sda_hold_high: assert property (
    i2c_scl_in [*4] |-> $stable(i2c_sda_oe_n))
    else $error("sda drive moved while scl high");
  a_busy_on_start: assert property (
    $fell(i2c_sda_in) && i2c_scl_in |-> ##[1:6] i2c_busy)
    else $error("start not seen");
  a_ptr_only_busy: assert property (
    $changed(i2c_pointer) |-> i2c_busy)
    else $error("pointer moved outside a transaction");
  ////////////////////////////////////////////////////////////////////////
  a_miso_oe_off: assert property (spi_ss_n [*4] |-> spi_miso_oe_n)
    else $error("miso driven while deselected");
  a_miso_oe_on: assert property (
    (!spi_ss_n) [*4] |-> !spi_miso_oe_n)
    else $error("miso not driven while selected");
  // flag may only move once the deselect has crossed the synchroniser
  a_ferr_deselect: assert property (
    $changed(spi_frame_error) |->
    spi_ss_n && $past(spi_ss_n) && $past(spi_ss_n, 2))
    else $error("frame error moved inside a frame");
endmodule
`default_nettype wire

// ===== tb/srap_host_model.sv
`timescale 1ns/10ps
`default_nettype none
module srap_host_model (
  input wire logic clk, // bench clock, paces every step
  output logic scl, // i2c clock, idles high
  output logic sda_low, // host pulls sda low
  input wire logic sda, // resolved sda level
  output logic sclk, // spi clock
  output logic ss_n, // spi select, low active
  output logic mosi, // spi host data
  input wire logic miso // spi client data
);
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
    sclk = 1'b0;
    ss_n = 1'b1;
    mosi = 1'b0;
  end
  // lines only move just after a clock edge
  task automatic w(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  ////////////////////////////////////////////////////////////////////////
  // also serves as repeated start, from idle or scl low
  task automatic start;
    w(3);
    sda_low = 1'b0;
    w(3);
    scl = 1'b1;
    w(3);
    sda_low = 1'b1;
    w(3);
    scl = 1'b0;
  endtask
  task automatic stop;
    w(3);
    sda_low = 1'b1;
    w(3);
    scl = 1'b1;
    w(3);
    sda_low = 1'b0;
  endtask
  // sampled late in the high phase, well clear of the client's edges
  task automatic bitx(input logic b, output logic r);
    w(3);
    sda_low = !b;
    w(3);
    scl = 1'b1;
    w(5);
    r = sda;
    w(1);
    scl = 1'b0;
  endtask
  // ack_bit 1 releases sda: client ack on writes, nack ends reads
  task automatic xfer(input logic [7:0] tx, input logic ack_bit,
                      output logic [7:0] rx, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      bitx(tx[i], rx[i]);
    end
    bitx(ack_bit, ack);
  endtask
  ////////////////////////////////////////////////////////////////////////
  // mosi moves with the falling edge, miso taken at the rise
  task automatic spi(input logic [31:0] tx, input int n,
                     output logic [31:0] rx);
    rx = '0;
    ss_n = 1'b0;
    for (int i = 31; i > 31 - n; i--) begin
      mosi = tx[i];
      w(4);
      sclk = 1'b1;
      rx[i] = miso;
      w(4);
      sclk = 1'b0;
    end
    w(4);
    ss_n = 1'b1;
    mosi = !mosi; // released line, no pull: show a wrong value
    w(6);
  endtask
  // deliberate chatter with select high
  task automatic noise;
    repeat (6) begin
      sclk = !sclk;
      mosi = !mosi;
      w(2);
    end
  endtask
endmodule
`default_nettype wire

// ===== tb/serial_register_access_port_tb.sv
`timescale 1ns/10ps
`default_nettype none
`include "srap_map.svh"
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin fail_count++; \
  $display("[ERR] %0t got %h exp %h", $time, g, e); end end
module serial_register_access_port_tb;
  import srap_pkg::*;
  logic ref_clk, rst, i2c_scl_in, i2c_sda_in, i2c_sda_out, i2c_sda_oe_n;
  logic spi_sclk, spi_ss_n, spi_mosi, spi_miso, spi_miso_oe_n;
  logic host_sda_low, i2c_busy, spi_frame_error, ack;
  logic [`SRAP_SENSOR_WIDTH-1:0] sensor_bytes;
  srap_byte_t i2c_pointer, rx;
  srap_byte_t shadow [256];
  srap_byte_t st [4] = '{8'hfe, 8'h62, 8'h64, 8'h68};
  srap_frame_t resp, sens_exp;
  int fail_count, checked;
  localparam logic [6:0] OA = `SRAP_I2C_OWN_ADDR;
  // pull-up on sda: low if either party pulls
  assign i2c_sda_in = !(host_sda_low || (!i2c_sda_oe_n && !i2c_sda_out));
  // sensor answer: command, zero nibble, status copy, 63h byte, zero crc
  assign sens_exp = {8'h30, sensor_bytes[7:0], sensor_bytes[23:16], 8'h00};
  srap_top dut_u (.ref_clk, .rst, .i2c_scl_in, .i2c_sda_in, .i2c_sda_out,
    .i2c_sda_oe_n, .spi_sclk, .spi_ss_n, .spi_mosi, .spi_miso,
    .spi_miso_oe_n, .sensor_bytes, .i2c_pointer, .i2c_busy,
    .spi_frame_error);
  srap_host_model host_u (.clk(ref_clk), .scl(i2c_scl_in),
    .sda_low(host_sda_low), .sda(i2c_sda_in), .sclk(spi_sclk),
    .ss_n(spi_ss_n), .mosi(spi_mosi), .miso(spi_miso));
  initial begin
    ref_clk = 1'b0;
    forever #10 ref_clk = !ref_clk;
  end
  ////////////////////////////////////////////////////////////////////////
  function automatic srap_byte_t exp_byte(input srap_byte_t a);
    if (a >= 8'h61 && a <= 8'h69) return sensor_bytes[(a-8'h61)*8 +: 8];
    return shadow[a];
  endfunction
  // wrap point follows bit 0 of the two select registers
  function automatic srap_byte_t next_ptr(input srap_byte_t a);
    case ({shadow[8'h45][0], shadow[8'h44][0]})
      2'b01: if (a == 8'h63) return 8'h61;
      2'b10: if (a == 8'h65) return 8'h61;
      2'b11: if (a == 8'h69) return 8'h61;
      default: ;
    endcase
    return a + 8'h01;
  endfunction
  task automatic i2c_wr(input srap_byte_t a, d0, d1);
    host_u.start();
    host_u.xfer({OA, 1'b0}, 1'b1, rx, ack);
    `CHK(ack, 1'b0)
    host_u.xfer(a, 1'b1, rx, ack);
    `CHK(ack, 1'b0)
    host_u.xfer(d0, 1'b1, rx, ack);
    host_u.xfer(d1, 1'b1, rx, ack);
    `CHK(ack, 1'b0)
    host_u.stop();
    shadow[a] = d0;
    shadow[a + 8'h01] = d1;
  endtask
  task automatic i2c_rd(input srap_byte_t a, input int n);
    i2c_wr_head(a);
    for (int k = 0; k < n; k++) begin
      host_u.xfer(8'hff, k == n - 1, rx, ack);
      `CHK(rx, exp_byte(a))
      a = next_ptr(a);
    end
    host_u.stop();
    `CHK(i2c_pointer, a)
  endtask
  task automatic i2c_wr_head(input srap_byte_t a);
    host_u.start();
    host_u.xfer({OA, 1'b0}, 1'b1, rx, ack);
    host_u.xfer(a, 1'b1, rx, ack);
    host_u.start();
    host_u.xfer({OA, 1'b1}, 1'b1, rx, ack);
    `CHK(ack, 1'b0)
  endtask
  task automatic wrap_up;
    $display("checks %0d errors %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    #1ms;
    fail_count++;
    wrap_up();
  end
  initial begin
    rst = 1'b1;
    for (int k = 0; k < 9; k++) sensor_bytes[8*k +: 8] = 8'ha0 + k[7:0];
    foreach (shadow[i]) shadow[i] = `SRAP_REG_RESET;
    repeat (4) @(posedge ref_clk);
    #1 rst = 1'b0;
    host_u.w(3);
    `CHK({i2c_pointer, i2c_busy, i2c_sda_oe_n}, 10'h001)
    `CHK({spi_frame_error, spi_miso_oe_n}, 2'b01)
    // each mode reads across its wrap point
    for (int m = 0; m < 4; m++) begin
      i2c_wr(8'h44, {7'h0, m[0]}, {7'h0, m[1]});
      i2c_rd(st[m], 3);
    end
    host_u.start();
    host_u.xfer({OA ^ 7'h01, 1'b0}, 1'b1, rx, ack);
    `CHK(ack, 1'b1)
    host_u.stop();
    host_u.w(4);
    `CHK(i2c_busy, 1'b0)
    host_u.spi(32'h2050_5ac3, 32, resp);
    shadow[8'h50] = 8'h5a;
    host_u.spi(32'h1050_0000, 32, resp);
    `CHK(resp, 32'h2050_5a00)
    host_u.noise();
    host_u.spi(32'h3000_0000, 32, resp);
    `CHK(resp, 32'h1050_5a00)
    host_u.spi(32'h3010_0000, 32, resp);
    `CHK(resp, sens_exp)
    host_u.spi(32'h2061_ff00, 32, resp);
    `CHK(resp, 32'h0)
    host_u.spi(32'h1061_0000, 32, resp);
    `CHK(resp, 32'h2061_ff00)
    host_u.spi(32'h4000_0000, 32, resp);
    `CHK(resp, {16'h1061, sensor_bytes[7:0], 8'h00})
    host_u.spi(32'h1050_0000, 16, resp);
    `CHK({resp, spi_frame_error}, 33'h1)
    host_u.spi(32'h1050_0000, 32, resp);
    `CHK(spi_frame_error, 1'b0)
    i2c_rd(8'h50, 1);
    wrap_up();
  end
endmodule
bind srap_top srap_top_monitor mon_u (.ref_clk, .rst, .i2c_scl_in,
  .i2c_sda_in, .i2c_sda_out, .i2c_sda_oe_n, .spi_ss_n, .spi_miso_oe_n,
  .i2c_pointer, .i2c_busy, .spi_frame_error);
`default_nettype wire
